// ==== t16cc_host.sv ====
// Host CPU model driving the byte port of the timer.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module t16cc_host (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] cpu_rdata_i,
  output var  logic [2:0] cpu_sel_o,
  output var  logic       cpu_rd_o,
  output var  logic       cpu_wr_o,
  output var  logic [7:0] cpu_wdata_o
);
  initial begin
    cpu_sel_o   = 3'h7;
    cpu_rd_o    = 1'b0;
    cpu_wr_o    = 1'b0;
    cpu_wdata_o = 8'h5a;
  end

  // One byte access, held until the taking edge
  task automatic acc(input logic [2:0] s, input logic w, input logic [7:0] d, output logic [7:0] q);
    cpu_sel_o   = s;
    cpu_rd_o    = !w;
    cpu_wr_o    = w;
    cpu_wdata_o = w ? d : ~cpu_wdata_o;
    @(posedge sys_clk_i);
    #1;
    q = cpu_rdata_i;
  endtask

  // Strobes drop low; select and data lines show the inverse of the last value
  task automatic idle();
    cpu_rd_o    = 1'b0;
    cpu_wr_o    = 1'b0;
    cpu_sel_o   = ~cpu_sel_o;
    cpu_wdata_o = ~cpu_wdata_o;
  endtask

  // Upper byte first, then lower
  task automatic wr16(input logic [2:0] lo, input logic [15:0] x);
    logic [7:0] q;
    acc(lo + 3'h1, 1'b1, x[15:8], q);
    acc(lo, 1'b1, x[7:0], q);
  endtask

  // Lower byte first, then upper
  task automatic rd16(input logic [2:0] lo, output logic [15:0] x);
    acc(lo, 1'b0, 8'h00, x[7:0]);
    acc(lo + 3'h1, 1'b0, 8'h00, x[15:8]);
  endtask
endmodule // t16cc_host
`default_nettype wire

// ==== t16cc_in_sync.sv ====
// Three-stage synchroniser with agreement filter for one asynchronous input.
// Assumes the input may change at any time relative to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module t16cc_in_sync (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output var  logic level_o
);

  logic s1_r, s2_r, s3_r, lvl_r;
  logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

  always_comb begin
    s1_nxt  = async_i;
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      s3_r  <= s3_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;

endmodule // t16cc_in_sync
`default_nettype wire

// ==== t16cc_mode_decode.sv ====
// Decodes the four-bit waveform mode into top value and counting shape.
// Assumes both top sources are stable registers of the caller.
`timescale 1ns/1ps
`default_nettype none
module t16cc_mode_decode (
  input  wire logic                       [3:0]  wgm_i,
  input  wire logic                       [15:0] compare_top_i,
  input  wire logic                       [15:0] capture_top_i,
  output logic                            [15:0] top_o,
  output logic                                   dual_slope_o,
  output logic                                   capture_is_top_o,
  output t16cc_pkg::t16cc_ovf_t                  ovf_at_o
);

  always_comb begin
    top_o            = t16cc_pkg::CNT_MAX;
    dual_slope_o     = 1'b0;
    capture_is_top_o = 1'b0;
    ovf_at_o         = t16cc_pkg::OVF_AT_MAX;
    unique case (wgm_i)
      4'h0: ;
      4'h1: begin top_o = t16cc_pkg::TOP_8BIT;  dual_slope_o = 1'b1; ovf_at_o = t16cc_pkg::OVF_AT_BOT; end
      4'h2: begin top_o = t16cc_pkg::TOP_9BIT;  dual_slope_o = 1'b1; ovf_at_o = t16cc_pkg::OVF_AT_BOT; end
      4'h3: begin top_o = t16cc_pkg::TOP_10BIT; dual_slope_o = 1'b1; ovf_at_o = t16cc_pkg::OVF_AT_BOT; end
      4'h4: top_o = compare_top_i;
      4'h5: begin top_o = t16cc_pkg::TOP_8BIT;  ovf_at_o = t16cc_pkg::OVF_AT_TOP; end
      4'h6: begin top_o = t16cc_pkg::TOP_9BIT;  ovf_at_o = t16cc_pkg::OVF_AT_TOP; end
      4'h7: begin top_o = t16cc_pkg::TOP_10BIT; ovf_at_o = t16cc_pkg::OVF_AT_TOP; end
      4'h8, 4'ha: begin
        top_o = capture_top_i;
        dual_slope_o = 1'b1;
        capture_is_top_o = 1'b1;
        ovf_at_o = t16cc_pkg::OVF_AT_BOT;
      end
      4'h9, 4'hb: begin top_o = compare_top_i; dual_slope_o = 1'b1; ovf_at_o = t16cc_pkg::OVF_AT_BOT; end
      4'hc: begin top_o = capture_top_i; capture_is_top_o = 1'b1; end
      4'hd: ;
      4'he: begin top_o = capture_top_i; capture_is_top_o = 1'b1; ovf_at_o = t16cc_pkg::OVF_AT_TOP; end
      4'hf: begin top_o = compare_top_i; ovf_at_o = t16cc_pkg::OVF_AT_TOP; end
    endcase
  end

endmodule // t16cc_mode_decode
`default_nettype wire

// ==== t16cc_pkg.sv ====
// Constants, field layouts and types of the sixteen-bit counter with capture.
// Assumes a single system clock; nothing here holds state.
package t16cc_pkg;

  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [15:0] CNT_ONE    = 16'h0001;

  // CPU byte locations
  localparam logic [2:0] LOC_CNT_LO = 3'h0;
  localparam logic [2:0] LOC_CNT_HI = 3'h1;
  localparam logic [2:0] LOC_CAP_LO = 3'h2;
  localparam logic [2:0] LOC_CAP_HI = 3'h3;
  localparam logic [2:0] LOC_FLAGS  = 3'h4;

  // Flag byte layout
  localparam int unsigned FLAG_OVF_BIT = 0;
  localparam int unsigned FLAG_CAP_BIT = 5;

  // Control byte fields
  localparam int unsigned WGM_LO_POS = 0;
  localparam int unsigned WGM_HI_POS = 3;
  localparam int unsigned CS_POS     = 0;
  localparam int unsigned EDGE_POS   = 6;

  // Clock select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler
  localparam logic [9:0] PRE_RST   = 10'h000;
  localparam logic [9:0] PRE_ONE   = 10'h001;
  localparam logic [9:0] PRE_M8    = 10'h007;
  localparam logic [9:0] PRE_M64   = 10'h03f;
  localparam logic [9:0] PRE_M256  = 10'h0ff;
  localparam logic [9:0] PRE_M1024 = 10'h3ff;

  // Point at which the overflow flag is set
  typedef enum logic [1:0] {
    OVF_AT_MAX = 2'b00,
    OVF_AT_TOP = 2'b01,
    OVF_AT_BOT = 2'b10
  } t16cc_ovf_t;

endpackage

// ==== t16cc_timer.sv ====
// Sixteen-bit up/down counter with input capture and shared high-byte holding register.
// Assumes a CPU byte port with at most one read or write per cycle; pins are asynchronous.
// Contract
// - Holding register keeps its value, so a shared upper byte is written once.
// - Three-bit clock select picks the tick; zero stops the counter.
// - Counter changes by one per step, up or down per direction, except that a single-slope step at top clears it.
// - Clear forces zero; bottom indication when the counter reaches zero.
// - Top indication when the counter reaches the highest value of its sequence.
// - Counter appears to the CPU as upper and lower byte locations.
// - Upper-byte location accesses go to the shared holding register.
// - Reading the counter lower byte copies its upper byte into the holding register.
// - Writing the counter lower byte loads all sixteen bits at once.
// - Each tick clears, counts up or counts down as the mode demands.
// - Counter stays readable and writable whether or not a tick runs.
// - A CPU counter write wins over a coinciding count or clear.
// - Counting follows a four-bit mode field split over two control bytes.
// - Overflow flag set at the mode's point and can raise an interrupt.
// - Capture trigger is the pin, or the comparator on the first timer only.
// - A matching edge copies the full counter into the capture register, except in modes where the capture register is top.
// - Capture flag set in the same cycle the counter is copied.
// - Capture flag with enable set raises a capture interrupt.
// - Capture flag clears on service or on a CPU write of one.
// - Capture lower-byte read copies upper byte to holding register first.
// - Capture register takes CPU writes only when it is the counter's top.
// - One holding register is shared by counter and capture register.
// - Counter maximum is all ones; bottom is zero.
`timescale 1ns/1ps
`default_nettype none
module t16cc_timer #(
  parameter bit HAS_COMPARATOR = 1'b1
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [2:0]  cpu_sel_i,
  input  wire logic        cpu_rd_i,
  input  wire logic        cpu_wr_i,
  input  wire logic [7:0]  cpu_wdata_i,
  output logic      [7:0]  cpu_rdata_o,
  input  wire logic [7:0]  timer_control_first_i,
  input  wire logic [7:0]  timer_control_second_i,
  input  wire logic [15:0] compare_top_i,
  input  wire logic        ext_clock_pin_i,
  input  wire logic        capture_pin_i,
  input  wire logic        comparator_output_i,
  input  wire logic        comparator_select_i,
  input  wire logic        capture_irq_enable_i,
  input  wire logic        overflow_irq_enable_i,
  input  wire logic        capture_irq_ack_i,
  input  wire logic        overflow_irq_ack_i,
  output logic      [15:0] count_value_o,
  output logic      [15:0] capture_value_o,
  output logic             top_o,
  output logic             bottom_o,
  output logic             overflow_flag_o,
  output logic             capture_flag_o,
  output logic             overflow_irq_o,
  output logic             capture_irq_o
);

  logic [3:0]              wgm;
  logic [2:0]              clk_sel;
  logic                    edge_rise;
  logic [15:0]             top_val;
  logic                    dual_slope;
  logic                    icr_top;
  t16cc_pkg::t16cc_ovf_t   ovf_at;
  logic                    pin_lvl, cmp_lvl, ext_lvl, src_lvl;

  logic [15:0] cnt_r, cnt_nxt, cnt_step, cap_r, cap_nxt;
  logic [7:0]  temp_r, temp_nxt, rdata_r, rdata_nxt;
  logic [9:0]  pre_r, pre_nxt;
  logic        dir_down_r, dir_down_nxt;
  logic        ext_prev_r, src_prev_r;
  logic        top_r, top_nxt, bot_r, bot_nxt;
  logic        ovf_flag_r, ovf_flag_nxt, cap_flag_r, cap_flag_nxt;
  logic        ovf_irq_r, cap_irq_r;
  logic        tick, cnt_write, step, ovf_evt, cap_evt, trig_edge;
  logic        flag_wr;

  assign wgm       = {timer_control_second_i[t16cc_pkg::WGM_HI_POS +: 2],
                      timer_control_first_i[t16cc_pkg::WGM_LO_POS +: 2]};
  assign clk_sel   = timer_control_second_i[t16cc_pkg::CS_POS +: 3];
  assign edge_rise = timer_control_second_i[t16cc_pkg::EDGE_POS];

  t16cc_mode_decode u_mode (
    .wgm_i            (wgm),
    .compare_top_i    (compare_top_i),
    .capture_top_i    (cap_r),
    .top_o            (top_val),
    .dual_slope_o     (dual_slope),
    .capture_is_top_o (icr_top),
    .ovf_at_o         (ovf_at)
  );

  t16cc_in_sync u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (capture_pin_i),
    .level_o   (pin_lvl)
  );

  t16cc_in_sync u_cmp_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (comparator_output_i),
    .level_o   (cmp_lvl)
  );

  t16cc_in_sync u_ext_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (ext_clock_pin_i),
    .level_o   (ext_lvl)
  );

  // Tick generation from prescaler or external pin
  always_comb begin
    pre_nxt = pre_r + t16cc_pkg::PRE_ONE;
    tick    = 1'b0;
    unique case (clk_sel)
      t16cc_pkg::CS_STOP:     tick = 1'b0;
      t16cc_pkg::CS_DIV1:     tick = 1'b1;
      t16cc_pkg::CS_DIV8:     tick = ((pre_r & t16cc_pkg::PRE_M8) == t16cc_pkg::PRE_M8);
      t16cc_pkg::CS_DIV64:    tick = ((pre_r & t16cc_pkg::PRE_M64) == t16cc_pkg::PRE_M64);
      t16cc_pkg::CS_DIV256:   tick = ((pre_r & t16cc_pkg::PRE_M256) == t16cc_pkg::PRE_M256);
      t16cc_pkg::CS_DIV1024:  tick = (pre_r == t16cc_pkg::PRE_M1024);
      t16cc_pkg::CS_EXT_FALL: tick = ext_prev_r & ~ext_lvl;
      t16cc_pkg::CS_EXT_RISE: tick = ~ext_prev_r & ext_lvl;
    endcase
  end

  // Counter, direction, top and bottom
  always_comb begin
    cnt_write    = cpu_wr_i && (cpu_sel_i == t16cc_pkg::LOC_CNT_LO);
    step         = tick && !cnt_write;
    dir_down_nxt = dual_slope ? dir_down_r : 1'b0;
    cnt_step     = cnt_r + t16cc_pkg::CNT_ONE;
    if (dual_slope) begin
      if (!dir_down_r && cnt_r >= top_val) begin
        dir_down_nxt = 1'b1;
        cnt_step     = cnt_r - t16cc_pkg::CNT_ONE;
      end else if (dir_down_r && cnt_r == t16cc_pkg::CNT_BOTTOM) begin
        dir_down_nxt = 1'b0;
      end else if (dir_down_r) begin
        cnt_step = cnt_r - t16cc_pkg::CNT_ONE;
      end
    end else if (cnt_r == top_val) begin
      cnt_step = t16cc_pkg::CNT_BOTTOM;
    end
    if (!step) begin
      dir_down_nxt = dir_down_r;
    end
    if (cnt_write) begin
      cnt_nxt = {temp_r, cpu_wdata_i};
    end else if (step) begin
      cnt_nxt = cnt_step;
    end else begin
      cnt_nxt = cnt_r;
    end
    top_nxt = (cnt_nxt == top_val);
    bot_nxt = (cnt_nxt == t16cc_pkg::CNT_BOTTOM);
    ovf_evt = 1'b0;
    unique case (ovf_at)
      t16cc_pkg::OVF_AT_MAX: ovf_evt = step && (cnt_r == t16cc_pkg::CNT_MAX);
      t16cc_pkg::OVF_AT_TOP: ovf_evt = step && (cnt_r == top_val);
      t16cc_pkg::OVF_AT_BOT: ovf_evt = step && (cnt_step == t16cc_pkg::CNT_BOTTOM);
      default:               ovf_evt = 1'b0;
    endcase
  end

  // Capture trigger, capture register and flags
  always_comb begin
    src_lvl   = (HAS_COMPARATOR && comparator_select_i) ? cmp_lvl : pin_lvl;
    trig_edge = edge_rise ? (src_lvl & ~src_prev_r) : (~src_lvl & src_prev_r);
    cap_evt   = trig_edge && !icr_top;
    flag_wr   = cpu_wr_i && (cpu_sel_i == t16cc_pkg::LOC_FLAGS);
    cap_nxt   = cap_r;
    if (cap_evt) begin
      cap_nxt = cnt_r;
    end else if (cpu_wr_i && cpu_sel_i == t16cc_pkg::LOC_CAP_LO && icr_top) begin
      cap_nxt = {temp_r, cpu_wdata_i};
    end
    cap_flag_nxt = cap_evt ||
                   (cap_flag_r && !capture_irq_ack_i &&
                    !(flag_wr && cpu_wdata_i[t16cc_pkg::FLAG_CAP_BIT]));
    ovf_flag_nxt = ovf_evt ||
                   (ovf_flag_r && !overflow_irq_ack_i &&
                    !(flag_wr && cpu_wdata_i[t16cc_pkg::FLAG_OVF_BIT]));
  end

  // CPU byte access through the shared holding register
  always_comb begin
    temp_nxt  = temp_r;
    rdata_nxt = rdata_r;
    if (cpu_wr_i && (cpu_sel_i == t16cc_pkg::LOC_CNT_HI || cpu_sel_i == t16cc_pkg::LOC_CAP_HI)) begin
      temp_nxt = cpu_wdata_i;
    end else if (cpu_rd_i && !cpu_wr_i) begin
      unique case (cpu_sel_i)
        t16cc_pkg::LOC_CNT_LO: begin
          rdata_nxt = cnt_r[7:0];
          temp_nxt  = cnt_r[15:8];
        end
        t16cc_pkg::LOC_CAP_LO: begin
          rdata_nxt = cap_r[7:0];
          temp_nxt  = cap_r[15:8];
        end
        t16cc_pkg::LOC_CNT_HI, t16cc_pkg::LOC_CAP_HI: rdata_nxt = temp_r;
        t16cc_pkg::LOC_FLAGS: begin
          rdata_nxt = t16cc_pkg::BYTE_RST;
          rdata_nxt[t16cc_pkg::FLAG_CAP_BIT] = cap_flag_r;
          rdata_nxt[t16cc_pkg::FLAG_OVF_BIT] = ovf_flag_r;
        end
        default: rdata_nxt = t16cc_pkg::BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r      <= t16cc_pkg::CNT_RST;
      cap_r      <= t16cc_pkg::CNT_RST;
      temp_r     <= t16cc_pkg::BYTE_RST;
      rdata_r    <= t16cc_pkg::BYTE_RST;
      pre_r      <= t16cc_pkg::PRE_RST;
      dir_down_r <= 1'b0;
      ext_prev_r <= 1'b0;
      src_prev_r <= 1'b0;
      top_r      <= 1'b0;
      bot_r      <= 1'b0;
      ovf_flag_r <= 1'b0;
      cap_flag_r <= 1'b0;
      ovf_irq_r  <= 1'b0;
      cap_irq_r  <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      cap_r      <= cap_nxt;
      temp_r     <= temp_nxt;
      rdata_r    <= rdata_nxt;
      pre_r      <= pre_nxt;
      dir_down_r <= dir_down_nxt;
      ext_prev_r <= ext_lvl;
      src_prev_r <= src_lvl;
      top_r      <= top_nxt;
      bot_r      <= bot_nxt;
      ovf_flag_r <= ovf_flag_nxt;
      cap_flag_r <= cap_flag_nxt;
      ovf_irq_r  <= ovf_flag_r && overflow_irq_enable_i;
      cap_irq_r  <= cap_flag_r && capture_irq_enable_i;
    end
  end

  assign cpu_rdata_o     = rdata_r;
  assign count_value_o   = cnt_r;
  assign capture_value_o = cap_r;
  assign top_o           = top_r;
  assign bottom_o        = bot_r;
  assign overflow_flag_o = ovf_flag_r;
  assign capture_flag_o  = cap_flag_r;
  assign overflow_irq_o  = ovf_irq_r;
  assign capture_irq_o   = cap_irq_r;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_cnt_lo_write;
    cpu_wr_i && cpu_sel_i == t16cc_pkg::LOC_CNT_LO;
  endsequence

  sequence s_cnt_lo_read;
    cpu_rd_i && !cpu_wr_i && cpu_sel_i == t16cc_pkg::LOC_CNT_LO;
  endsequence

  sequence s_cnt_hi_read;
    cpu_rd_i && !cpu_wr_i && cpu_sel_i == t16cc_pkg::LOC_CNT_HI;
  endsequence

  chk_stop_holds: assert property (clk_sel == t16cc_pkg::CS_STOP && !cpu_wr_i |=> $stable(cnt_r))
    else $error("counter moved with no clock selected");
  chk_step_by_one: assert property (tick && !cpu_wr_i && (dual_slope || cnt_r != top_val)
      |=> (cnt_r == $past(cnt_r) + 16'h0001) || (cnt_r == $past(cnt_r) - 16'h0001))
    else $error("counter step was not one");
  chk_write_wins: assert property (s_cnt_lo_write |=> cnt_r == {$past(temp_r), $past(cpu_wdata_i)})
    else $error("counter write lost");
  chk_read_latch: assert property (s_cnt_lo_read |=> temp_r == $past(cnt_r[15:8]) &&
      cpu_rdata_o == $past(cnt_r[7:0]))
    else $error("holding register not loaded on lower read");
  chk_upper_read: assert property (s_cnt_lo_read ##1 s_cnt_hi_read
      |=> cpu_rdata_o == $past(cnt_r[15:8], 2))
    else $error("upper read did not return latched byte");
  chk_capture_copy: assert property (cap_evt |=> cap_r == $past(cnt_r) && cap_flag_r)
    else $error("capture copy or flag missing");
  chk_cap_wr_block: assert property (cpu_wr_i && cpu_sel_i == t16cc_pkg::LOC_CAP_LO
      && !icr_top && !cap_evt |=> $stable(cap_r))
    else $error("capture written outside top mode");
  chk_cap_irq: assert property (cap_flag_r && capture_irq_enable_i |=> capture_irq_o)
    else $error("capture interrupt not raised");
  chk_cap_clear: assert property (capture_irq_ack_i && !cap_evt
      |=> !cap_flag_r ##1 (cap_flag_r == $past(cap_evt)))
    else $error("capture flag not cleared");
  chk_bottom_ind: assert property (step && cnt_step == 16'h0000 |=> bottom_o && cnt_r == 16'h0000)
    else $error("bottom not indicated");

endmodule // t16cc_timer
`default_nettype wire

// ==== timer16_counter_capture_test.sv ====
// Self-checking bench for the sixteen-bit counter with capture.
// Assumes the host model drives the byte port; pins and control bytes come from here.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) check(nm, 16'(e), 16'(g))
module timer16_counter_capture_test;
  logic        sys_clk_i, reset_i, rd, wr, ext_pin, cap_pin, cmp_out, cmp_sel;
  logic        cap_ie, ovf_ie, cap_ack, ovf_ack, top, bot, ovf_flag, cap_flag, ovf_irq, cap_irq;
  logic [2:0]  sel;
  logic [7:0]  wdata, rdata, ctl_a, ctl_b, b, h;
  logic [15:0] cmp_top, cnt, cap, v;
  int          fails, compares, seed, m_cnt, m_cap, k, j, up;
  int          shift [5] = '{0, 3, 6, 8, 10};

  t16cc_host i_t16cc_host (.sys_clk_i(sys_clk_i), .cpu_rdata_i(rdata), .cpu_sel_o(sel), .cpu_rd_o(rd),
    .cpu_wr_o(wr), .cpu_wdata_o(wdata));
  t16cc_timer #(.HAS_COMPARATOR(1'b1)) i_t16cc_timer (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .cpu_sel_i(sel), .cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
    .timer_control_first_i(ctl_a), .timer_control_second_i(ctl_b), .compare_top_i(cmp_top),
    .ext_clock_pin_i(ext_pin), .capture_pin_i(cap_pin), .comparator_output_i(cmp_out),
    .comparator_select_i(cmp_sel), .capture_irq_enable_i(cap_ie), .overflow_irq_enable_i(ovf_ie),
    .capture_irq_ack_i(cap_ack), .overflow_irq_ack_i(ovf_ack), .count_value_o(cnt), .capture_value_o(cap),
    .top_o(top), .bottom_o(bot), .overflow_flag_o(ovf_flag), .capture_flag_o(cap_flag),
    .overflow_irq_o(ovf_irq), .capture_irq_o(cap_irq));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic acc(input logic [2:0] s, input logic w, input logic [7:0] d);
    i_t16cc_host.acc(s, w, d, b);
    i_t16cc_host.idle();
    step(1);
  endtask

  task automatic wr16(input logic [2:0] lo, input logic [15:0] x);
    i_t16cc_host.wr16(lo, x);
    i_t16cc_host.idle();
    step(1);
  endtask

  task automatic rdv(input logic [2:0] lo, input int e);
    i_t16cc_host.rd16(lo, v);
    i_t16cc_host.idle();
    step(1);
    `CHECK("16-bit read", e, v);
  endtask

  task automatic run(input logic [2:0] cs, input int n);
    ctl_b[2:0] = cs;
    step(n);
    ctl_b[2:0] = t16cc_pkg::CS_STOP;
    step(1);
  endtask

  task automatic mode(input logic [3:0] m);
    ctl_a[1:0] = m[1:0];
    ctl_b[4:3] = m[3:2];
  endtask

  task automatic cap_wait(input string nm);
    for (k = 0; k < 20 && cap_flag !== 1'b1; k++) begin
      step(1);
    end
    if (cap_flag !== 1'b1) begin
      fails++;
      results();
    end
    `CHECK(nm, m_cnt, cap);
  endtask

  initial begin
    seed = 36;
    fails = 0;
    compares = 0;
    reset_i = 1'b1;
    {ctl_a, ctl_b, ext_pin, cap_pin, cmp_out, cmp_sel, cap_ie, ovf_ie, cap_ack, ovf_ack} = '0;
    cmp_top = 16'($random(seed));
    repeat (5) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    step(1);
    `CHECK("count after reset", 0, cnt);
    `CHECK("capture after reset", 0, cap);
    `CHECK("flags after reset", 0, {ovf_flag, cap_flag, ovf_irq, cap_irq});
    `CHECK("bottom after reset", 1, bot);
    rdv(t16cc_pkg::LOC_CNT_LO, 0);
    acc(3'h5, 1'b0, 8'h00);
    `CHECK("unmapped read", 0, b);
    // Stopped counter written and read back
    for (j = 0; j < 4; j++) begin
      m_cnt = 16'($random(seed));
      wr16(t16cc_pkg::LOC_CNT_LO, 16'(m_cnt));
      step(3);
      `CHECK("count held", m_cnt, cnt);
      rdv(t16cc_pkg::LOC_CNT_LO, m_cnt);
    end
    // One upper byte serving two lower writes
    h = 8'($random(seed));
    acc(t16cc_pkg::LOC_CNT_HI, 1'b1, h);
    acc(t16cc_pkg::LOC_CNT_LO, 1'b1, 8'($random(seed)));
    acc(t16cc_pkg::LOC_CNT_LO, 1'b1, 8'h3c);
    m_cnt = {h, 8'h3c};
    `CHECK("shared upper byte", m_cnt, cnt);
    acc(t16cc_pkg::LOC_CAP_HI, 1'b0, 8'h00);
    `CHECK("holding via capture upper", h, b);
    // Limits of the count
    wr16(t16cc_pkg::LOC_CNT_LO, t16cc_pkg::CNT_MAX);
    `CHECK("top at max", 1, top);
    wr16(t16cc_pkg::LOC_CNT_LO, t16cc_pkg::CNT_BOTTOM);
    `CHECK("bottom at zero", 1, bot);
    // Overflow in normal mode
    ovf_ie = 1'b1;
    wr16(t16cc_pkg::LOC_CNT_LO, 16'hfffd);
    run(t16cc_pkg::CS_DIV1, 5);
    m_cnt = 2;
    `CHECK("count past max", m_cnt, cnt);
    `CHECK("overflow flag and irq", 2'b11, {ovf_flag, ovf_irq});
    acc(t16cc_pkg::LOC_FLAGS, 1'b0, 8'h00);
    `CHECK("flag byte", 1, b[t16cc_pkg::FLAG_OVF_BIT]);
    acc(t16cc_pkg::LOC_FLAGS, 1'b1, 8'h01);
    `CHECK("overflow cleared", 0, ovf_flag);
    // Write while counting wins
    ctl_b[2:0] = t16cc_pkg::CS_DIV1;
    step(2);
    m_cnt = 16'($random(seed));
    i_t16cc_host.wr16(t16cc_pkg::LOC_CNT_LO, 16'(m_cnt));
    `CHECK("write over tick", m_cnt, cnt);
    ctl_b[2:0] = t16cc_pkg::CS_STOP;
    i_t16cc_host.idle();
    step(1);
    // Every internal clock select
    for (j = 1; j < 6; j++) begin
      run(3'(j), 1024);
      m_cnt += 1024 >> shift[j - 1];
      `CHECK("prescaled count", 16'(m_cnt), cnt);
    end
    // External clock edges, falling then rising
    for (j = 6; j < 8; j++) begin
      ctl_b[2:0] = 3'(j);
      repeat (6) begin
        ext_pin = ~ext_pin;
        step(4);
      end
      step(8);
      ctl_b[2:0] = t16cc_pkg::CS_STOP;
      step(1);
      m_cnt += 3;
      `CHECK("external count", 16'(m_cnt), cnt);
    end
    // Dual slope with fixed top
    mode(4'h1);
    wr16(t16cc_pkg::LOC_CNT_LO, t16cc_pkg::TOP_8BIT);
    `CHECK("dual slope top", 1, top);
    m_cnt = 16'h00fd;
    wr16(t16cc_pkg::LOC_CNT_LO, 16'(m_cnt));
    run(t16cc_pkg::CS_DIV1, 5);
    up = 1;
    for (j = 0; j < 5; j++) begin
      if (m_cnt == 255) begin
        up = 0;
      end
      m_cnt = up ? m_cnt + 1 : m_cnt - 1;
    end
    `CHECK("dual slope count", m_cnt, cnt);
    // Clear at compare top
    mode(4'h4);
    wr16(t16cc_pkg::LOC_CNT_LO, cmp_top);
    `CHECK("compare top", 1, top);
    run(t16cc_pkg::CS_DIV1, 1);
    `CHECK("clear at compare top", 0, cnt);
    `CHECK("bottom after clear", 1, bot);
    // Fast mode with fixed top, overflow serviced
    mode(4'h5);
    acc(t16cc_pkg::LOC_FLAGS, 1'b1, 8'h01);
    wr16(t16cc_pkg::LOC_CNT_LO, 16'h00fe);
    run(t16cc_pkg::CS_DIV1, 3);
    `CHECK("fast mode wrap", 1, cnt);
    `CHECK("overflow at top", 1, ovf_flag);
    ovf_ack = 1'b1;
    step(1);
    ovf_ack = 1'b0;
    `CHECK("overflow after service", 0, ovf_flag);
    // Capture on pin edges
    mode(4'h0);
    ctl_b[6] = 1'b1;
    cap_ie = 1'b1;
    m_cnt = 16'($random(seed));
    wr16(t16cc_pkg::LOC_CNT_LO, 16'(m_cnt));
    cap_pin = 1'b1;
    cap_wait("rising capture");
    step(1);
    `CHECK("capture irq", 1, cap_irq);
    rdv(t16cc_pkg::LOC_CAP_LO, m_cnt);
    cap_ack = 1'b1;
    step(1);
    cap_ack = 1'b0;
    step(1);
    `CHECK("flag after service", 0, cap_flag);
    ctl_b[6] = 1'b0;
    m_cnt = 16'($random(seed));
    wr16(t16cc_pkg::LOC_CNT_LO, 16'(m_cnt));
    cap_pin = 1'b0;
    cap_wait("falling capture");
    acc(t16cc_pkg::LOC_FLAGS, 1'b1, 8'h20);
    `CHECK("flag after write", 0, cap_flag);
    // Comparator as source
    cmp_sel = 1'b1;
    ctl_b[6] = 1'b1;
    step(8);
    acc(t16cc_pkg::LOC_FLAGS, 1'b1, 8'h20);
    m_cnt = 16'($random(seed));
    wr16(t16cc_pkg::LOC_CNT_LO, 16'(m_cnt));
    cmp_out = 1'b1;
    cap_wait("comparator capture");
    // Capture register writes by mode
    m_cap = m_cnt;
    wr16(t16cc_pkg::LOC_CAP_LO, 16'($random(seed)));
    `CHECK("capture write refused", m_cap, cap);
    mode(4'hc);
    m_cap = 16'($random(seed));
    wr16(t16cc_pkg::LOC_CAP_LO, 16'(m_cap));
    `CHECK("capture write taken", m_cap, cap);
    results();
  end
endmodule // timer16_counter_capture_test
`undef CHECK
`default_nettype wire
